/* verilog/gpp_port_pair.sv */
// Top: two GPIO ports with direction, latch, override and standby isolation, pull-up on port A only
`timescale 1ns/1ps

module gpp_port_pair #(
  parameter logic [7:0] OPEN_DRAIN_A = 8'h00,         // Open-drain pins of port A
  parameter logic [7:0] OPEN_DRAIN_B = 8'h00          // Open-drain pins of port B
) (
  input  wire logic       i_ref_clk,                  // System clock, 40 MHz
  input  wire logic       i_rst,                      // Sync reset, active high
  input  wire logic [3:0] i_addr,                     // Register address
  input  wire logic [7:0] i_wdata,                    // Write data
  input  wire logic       i_wr,                       // Write strobe
  input  wire logic       i_rd,                       // Read strobe
  input  wire logic       i_rd_rmw,                   // Read is read-modify-write type
  output logic      [7:0] o_rdata,                    // Read data, cycle after strobe
  input  wire logic       i_standby,                  // Stop or watch mode active
  input  wire logic [7:0] i_pin_a,                    // Port A pad levels
  input  wire logic [7:0] i_pin_b,                    // Port B pad levels
  input  wire logic [7:0] i_periph_oe_a,              // Peripheral output enables, A
  input  wire logic [7:0] i_periph_out_a,             // Peripheral output levels, A
  input  wire logic [7:0] i_periph_oe_b,              // Peripheral output enables, B
  input  wire logic [7:0] i_periph_out_b,             // Peripheral output levels, B
  output logic      [7:0] o_pin_a,                    // Port A drive level
  output logic      [7:0] o_pin_a_oe_n,               // Port A enable, low drives
  output logic      [7:0] o_pin_b,                    // Port B drive level
  output logic      [7:0] o_pin_b_oe_n,               // Port B enable, low drives
  output logic      [7:0] o_pullup_a,                 // Port A pull-up connect
  output logic      [7:0] o_in_a,                     // Port A gated input to peripherals
  output logic      [7:0] o_in_b,                     // Port B gated input to peripherals
  output logic            o_ext_irq_six_input,        // Level to interrupt circuit
  output logic            o_ext_irq_seven_input       // Level to interrupt circuit
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] port_a_data_latch_q;
  logic [7:0] port_a_direction_q;
  logic [7:0] port_a_pullup_enable_q;
  logic [7:0] port_b_data_latch_q;
  logic [7:0] port_b_direction_q;
  logic [2:0] standby_control_q;

  logic [7:0] sync1_a_q;
  logic [7:0] sync2_a_q;
  logic [7:0] sync3_a_q;
  logic [7:0] pin_a_q;
  logic [7:0] sync1_b_q;
  logic [7:0] sync2_b_q;
  logic [7:0] sync3_b_q;
  logic [7:0] pin_b_q;

  logic       isolate;
  logic [7:0] in_keep_a;
  logic [7:0] in_keep_b;
  logic [7:0] drv_a_d;
  logic [7:0] en_a_d;
  logic [7:0] drv_b_d;
  logic [7:0] en_b_d;
  logic [7:0] rdata_d;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      port_a_data_latch_q <= gpp_pkg::RST_DATA;
      port_b_data_latch_q <= gpp_pkg::RST_DATA;
    end else if (i_wr && i_addr == gpp_pkg::OFS_A_DATA) begin
      port_a_data_latch_q <= i_wdata;
    end else if (i_wr && i_addr == gpp_pkg::OFS_B_DATA) begin
      port_b_data_latch_q <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      port_a_direction_q <= gpp_pkg::RST_DIR;
      port_b_direction_q <= gpp_pkg::RST_DIR;
    end else if (i_wr && i_addr == gpp_pkg::OFS_A_DIR) begin
      port_a_direction_q <= i_wdata;
    end else if (i_wr && i_addr == gpp_pkg::OFS_B_DIR) begin
      port_b_direction_q <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      port_a_pullup_enable_q <= gpp_pkg::RST_PULLUP;
      standby_control_q      <= gpp_pkg::RST_STANDBY;
    end else if (i_wr && i_addr == gpp_pkg::OFS_A_PULLUP) begin
      port_a_pullup_enable_q <= i_wdata;
    end else if (i_wr && i_addr == gpp_pkg::OFS_STANDBY) begin
      standby_control_q      <= i_wdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Pad input synchronisers
  // ----------------------------------------------------------------
  // Level updates only when stages two and three agree
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sync1_a_q <= 8'h00;
      sync2_a_q <= 8'h00;
      sync3_a_q <= 8'h00;
      pin_a_q   <= 8'h00;
      sync1_b_q <= 8'h00;
      sync2_b_q <= 8'h00;
      sync3_b_q <= 8'h00;
      pin_b_q   <= 8'h00;
    end else begin
      sync1_a_q <= i_pin_a;
      sync2_a_q <= sync1_a_q;
      sync3_a_q <= sync2_a_q;
      pin_a_q   <= (sync2_a_q & sync3_a_q) | (pin_a_q & (sync2_a_q ^ sync3_a_q));
      sync1_b_q <= i_pin_b;
      sync2_b_q <= sync1_b_q;
      sync3_b_q <= sync2_b_q;
      pin_b_q   <= (sync2_b_q & sync3_b_q) | (pin_b_q & (sync2_b_q ^ sync3_b_q));
    end
  end

  // ----------------------------------------------------------------
  // Pin drive and isolation
  // ----------------------------------------------------------------
  assign isolate = i_standby && standby_control_q[gpp_pkg::STB_PIN_STATE];

  // Interrupt inputs on port B bits 6 and 7 stay live when enabled
  assign in_keep_a = 8'h00;
  assign in_keep_b = {standby_control_q[gpp_pkg::STB_IRQ7_EN],
                      standby_control_q[gpp_pkg::STB_IRQ6_EN], 6'h00};

  // Software keeps peripheral outputs off while using a pin as port
  always_comb begin
    drv_a_d = (i_periph_oe_a & i_periph_out_a) |
              (~i_periph_oe_a & port_a_data_latch_q);
    en_a_d  = (i_periph_oe_a | port_a_direction_q) & gpp_pkg::PORT_A_MASK;
    en_a_d  = en_a_d & ~(OPEN_DRAIN_A & drv_a_d);
    drv_b_d = (i_periph_oe_b & i_periph_out_b) |
              (~i_periph_oe_b & port_b_data_latch_q);
    en_b_d  = (i_periph_oe_b | port_b_direction_q) & gpp_pkg::PORT_B_MASK;
    en_b_d  = en_b_d & ~(OPEN_DRAIN_B & drv_b_d);
    if (isolate) begin
      en_a_d = 8'h00;
      en_b_d = 8'h00;
    end
  end

  // Registered pad drive adds one cycle after a latch write
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_pin_a      <= 8'h00;
      o_pin_a_oe_n <= 8'hFF;
      o_pin_b      <= 8'h00;
      o_pin_b_oe_n <= 8'hFF;
      o_pullup_a   <= 8'h00;
    end else begin
      o_pin_a      <= drv_a_d & gpp_pkg::PORT_A_MASK;
      o_pin_a_oe_n <= ~en_a_d;
      o_pin_b      <= drv_b_d & gpp_pkg::PORT_B_MASK;
      o_pin_b_oe_n <= ~en_b_d;
      o_pullup_a   <= port_a_pullup_enable_q & gpp_pkg::PORT_A_PU_MASK &
                      ~(en_a_d & ~drv_a_d);
    end
  end

  // ----------------------------------------------------------------
  // Inputs to peripherals and interrupt circuit
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_in_a                <= 8'h00;
      o_in_b                <= 8'h00;
      o_ext_irq_six_input   <= 1'b0;
      o_ext_irq_seven_input <= 1'b0;
    end else begin
      o_in_a <= (isolate ? (pin_a_q & in_keep_a) : pin_a_q) & gpp_pkg::PORT_A_MASK;
      o_in_b <= (isolate ? (pin_b_q & in_keep_b) : pin_b_q) & gpp_pkg::PORT_B_MASK;
      // Level always passes, even in isolation; software masks unused irqs
      o_ext_irq_six_input   <= pin_b_q[6];
      o_ext_irq_seven_input <= pin_b_q[7];
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = gpp_pkg::RD_UNMAPPED;
    if (i_addr == gpp_pkg::OFS_A_DATA) begin
      if (i_rd_rmw) begin
        rdata_d = port_a_data_latch_q;
      end else begin
        rdata_d = (port_a_direction_q & ~i_periph_oe_a & port_a_data_latch_q) |
                  (~(port_a_direction_q & ~i_periph_oe_a) & pin_a_q);
      end
    end else if (i_addr == gpp_pkg::OFS_A_DIR) begin
      rdata_d = port_a_direction_q;
    end else if (i_addr == gpp_pkg::OFS_A_PULLUP) begin
      rdata_d = port_a_pullup_enable_q;
    end else if (i_addr == gpp_pkg::OFS_B_DATA) begin
      if (i_rd_rmw) begin
        rdata_d = port_b_data_latch_q;
      end else begin
        rdata_d = (port_b_direction_q & ~i_periph_oe_b & port_b_data_latch_q) |
                  (~(port_b_direction_q & ~i_periph_oe_b) & pin_b_q);
      end
    end else if (i_addr == gpp_pkg::OFS_B_DIR) begin
      rdata_d = port_b_direction_q;
    end else if (i_addr == gpp_pkg::OFS_STANDBY) begin
      rdata_d = {5'h00, standby_control_q};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rdata_d;
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule // gpp_port_pair

/* verilog/gpp_pkg.sv */
// Package: register map, pin masks and reset values for the two-port GPIO block
package gpp_pkg;
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 8;
  // Register offsets
  localparam logic [3:0]  OFS_A_DATA      = 4'h0;
  localparam logic [3:0]  OFS_A_DIR       = 4'h1;
  localparam logic [3:0]  OFS_A_PULLUP    = 4'h2;
  localparam logic [3:0]  OFS_B_DATA      = 4'h3;
  localparam logic [3:0]  OFS_B_DIR       = 4'h4;
  localparam logic [3:0]  OFS_STANDBY     = 4'h5;
  // Standby control field positions
  localparam int          STB_PIN_STATE   = 0;
  localparam int          STB_IRQ6_EN     = 1;
  localparam int          STB_IRQ7_EN     = 2;
  // Implemented pin positions
  localparam logic [7:0]  PORT_A_MASK     = 8'h39;
  localparam logic [7:0]  PORT_B_MASK     = 8'hC0;
  // Pins of port A that have a pull-up
  localparam logic [7:0]  PORT_A_PU_MASK  = 8'h38;
  // Reset values
  localparam logic [7:0]  RST_DATA        = 8'h00;
  localparam logic [7:0]  RST_DIR         = 8'h00;
  localparam logic [7:0]  RST_PULLUP      = 8'h00;
  localparam logic [2:0]  RST_STANDBY     = 3'h0;
  localparam logic [7:0]  RD_UNMAPPED     = 8'h00;
endpackage

/* tb/gpp_port_pair_asserts.sv */
// Checker: port-level properties of the two-port GPIO block
`timescale 1ns/1ps

module gpp_port_pair_asserts (
  input wire logic       i_ref_clk,           // Clock
  input wire logic       i_rst,               // Reset
  input wire logic [3:0] i_addr,              // Address
  input wire logic [7:0] i_wdata,             // Write data
  input wire logic       i_wr,                // Write
  input wire logic       i_rd,                // Read
  input wire logic       i_standby,           // Standby
  input wire logic [7:0] o_rdata,             // Read data
  input wire logic [7:0] o_pin_a,             // A drive
  input wire logic [7:0] o_pin_a_oe_n,        // A enable
  input wire logic [7:0] o_pin_b,             // B drive
  input wire logic [7:0] o_pin_b_oe_n,        // B enable
  input wire logic [7:0] o_pullup_a,          // A pull-up
  input wire logic [7:0] o_in_a,              // A input
  input wire logic [7:0] o_in_b,              // B input
  input wire logic       o_ext_irq_six_input  // Irq level
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic [2:0] stb_q;  // Shadow of standby control, write-only view
  logic       iso;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) stb_q <= 3'h0;
    else if (i_wr && i_addr == gpp_pkg::OFS_STANDBY) stb_q <= i_wdata[2:0];
  end
  assign iso = i_standby && stb_q[0];
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_dir_wr; i_wr && i_addr == gpp_pkg::OFS_A_DIR; endsequence
  sequence s_dir_rd; i_rd && !i_wr && i_addr == gpp_pkg::OFS_A_DIR; endsequence
  property p_dir_back; s_dir_wr ##2 s_dir_rd |=> o_rdata == $past(i_wdata, 3); endproperty
  property p_rd_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
  property p_reset_oe; $past(i_rst) |-> (o_pin_a_oe_n & o_pin_b_oe_n) == 8'hFF; endproperty
  property p_unimpl;
    (o_pin_a & ~gpp_pkg::PORT_A_MASK) == 8'h00 && (o_pin_b & ~gpp_pkg::PORT_B_MASK) == 8'h00
      && (o_pin_a_oe_n | gpp_pkg::PORT_A_MASK) == 8'hFF
      && (o_pin_b_oe_n | gpp_pkg::PORT_B_MASK) == 8'hFF;
  endproperty
  property p_pu_mask; (o_pullup_a & ~gpp_pkg::PORT_A_PU_MASK) == 8'h00; endproperty
  property p_pu_low; (o_pullup_a & ~o_pin_a_oe_n & ~o_pin_a) == 8'h00; endproperty
  property p_iso_hiz; iso [*2] |-> (o_pin_a_oe_n & o_pin_b_oe_n) == 8'hFF; endproperty
  property p_iso_in;
    iso [*2] |-> o_in_a == 8'h00 && (o_in_b & ~{stb_q[2:1], 6'h00}) == 8'h00;
  endproperty
  property p_irq; !iso [*2] |-> o_ext_irq_six_input == o_in_b[6]; endproperty
  a_dir_back: assert property (p_dir_back) else $error("direction readback wrong");
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  a_reset_oe: assert property (p_reset_oe) else $error("pin driven after reset");
  a_unimpl: assert property (p_unimpl) else $error("absent pin position active");
  a_pu_mask: assert property (p_pu_mask) else $error("pull-up on pin without one");
  a_pu_low: assert property (p_pu_low) else $error("pull-up while driving low");
  a_iso_hiz: assert property (p_iso_hiz) else $error("pin driven in isolation");
  a_iso_in: assert property (p_iso_in) else $error("input not held low");
  a_irq: assert property (p_irq) else $error("irq level not following pin");
endmodule // gpp_port_pair_asserts

bind gpp_port_pair gpp_port_pair_asserts u_chk (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .i_standby(i_standby), .o_rdata(o_rdata), .o_pin_a(o_pin_a),
  .o_pin_a_oe_n(o_pin_a_oe_n), .o_pin_b(o_pin_b), .o_pin_b_oe_n(o_pin_b_oe_n),
  .o_pullup_a(o_pullup_a), .o_in_a(o_in_a), .o_in_b(o_in_b),
  .o_ext_irq_six_input(o_ext_irq_six_input));

/* tb/gpp_pad_model.sv */
// Partner: pad levels of one port from port drive, external driver and pull-up
`timescale 1ns/1ps

module gpp_pad_model (
  input  wire logic       i_ref_clk,  // Clock
  input  wire logic [7:0] i_drv,      // Port drive level
  input  wire logic [7:0] i_oe_n,     // Port enable, low drives
  input  wire logic [7:0] i_pullup,   // Pull-up connect
  input  wire logic [7:0] i_ext,      // External driver level
  input  wire logic [7:0] i_ext_en,   // External driver on
  output logic      [7:0] o_pad       // Resolved pad level
);
  // A floating pad wanders, so no test can lean on a stale level
  logic [7:0] float_q = 8'h55;
  always @(posedge i_ref_clk) float_q <= ~float_q;
  assign o_pad = (~i_oe_n & i_drv) | (i_oe_n & i_ext_en & i_ext)
               | (i_oe_n & ~i_ext_en & (i_pullup | float_q));
endmodule // gpp_pad_model

/* tb/tb_gpio_port_pair_ctrl.sv */
// Testbench: register-level scenarios for the two-port GPIO block
`timescale 1ns/1ps

module tb_gpio_port_pair_ctrl;
  logic       i_ref_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_rd_rmw = 1'b0;
  logic       i_standby = 1'b0, irq6, irq7;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00, oe_a = 8'h00, out_a = 8'h00, oe_b = 8'h00, out_b = 8'h00;
  logic [7:0] ext_a = 8'h00, ext_b = 8'h00, en_a = 8'h00, en_b = 8'h00, pin_a, pin_b;
  logic [7:0] o_rdata, o_pin_a, o_pin_a_oe_n, o_pin_b, o_pin_b_oe_n, o_pullup_a, o_in_a, o_in_b;
  int         n_fail = 0, check_count = 0, cycles = 0;

  always #12.5 i_ref_clk = ~i_ref_clk;

  gpp_port_pair #(.OPEN_DRAIN_A(8'h20), .OPEN_DRAIN_B(8'h00)) u_dut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .i_rd_rmw(i_rd_rmw), .o_rdata(o_rdata), .i_standby(i_standby),
    .i_pin_a(pin_a), .i_pin_b(pin_b), .i_periph_oe_a(oe_a), .i_periph_out_a(out_a),
    .i_periph_oe_b(oe_b), .i_periph_out_b(out_b), .o_pin_a(o_pin_a),
    .o_pin_a_oe_n(o_pin_a_oe_n), .o_pin_b(o_pin_b), .o_pin_b_oe_n(o_pin_b_oe_n),
    .o_pullup_a(o_pullup_a), .o_in_a(o_in_a), .o_in_b(o_in_b),
    .o_ext_irq_six_input(irq6), .o_ext_irq_seven_input(irq7));
  gpp_pad_model u_pad_a (.i_ref_clk(i_ref_clk), .i_drv(o_pin_a), .i_oe_n(o_pin_a_oe_n),
    .i_pullup(o_pullup_a), .i_ext(ext_a), .i_ext_en(en_a), .o_pad(pin_a));
  gpp_pad_model u_pad_b (.i_ref_clk(i_ref_clk), .i_drv(o_pin_b), .i_oe_n(o_pin_b_oe_n),
    .i_pullup(8'h00), .i_ext(ext_b), .i_ext_en(en_b), .o_pad(pin_b));

  task automatic report_and_stop;
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic rmw, input logic [7:0] exp);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_rd_rmw <= rmw;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    i_rd_rmw <= 1'b0;
    #1 check(o_rdata, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  // Hang guard: the whole sequence needs under a hundred cycles
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    for (int a = 0; a < 6; a++) rd(a[3:0], a == 0 || a == 3, 8'h00);
    wr(4'h6, 8'hFF);
    rd(4'h6, 1'b0, 8'h00);
    wr(gpp_pkg::OFS_A_DIR, 8'hFF);
    rd(gpp_pkg::OFS_A_DIR, 1'b0, 8'hFF);
    wr(gpp_pkg::OFS_A_PULLUP, 8'hFF);
    wr(gpp_pkg::OFS_A_DATA, 8'hA5);
    idle(4);
    check(o_pin_a & 8'h19, 8'h01);
    check(o_pin_a_oe_n, 8'hE6);
    check(o_pullup_a, 8'h20);
    rd(gpp_pkg::OFS_A_DATA, 1'b0, 8'hA5);
    wr(gpp_pkg::OFS_A_DIR, 8'h00);
    ext_a <= 8'h5A;
    en_a <= 8'hFF;
    wr(gpp_pkg::OFS_A_DATA, 8'h3C);
    idle(8);
    check(o_pin_a_oe_n, 8'hFF);
    check(o_in_a & gpp_pkg::PORT_A_MASK, 8'h18);
    rd(gpp_pkg::OFS_A_DATA, 1'b0, 8'h5A);
    rd(gpp_pkg::OFS_A_DATA, 1'b1, 8'h3C);
    ext_b <= 8'h15;
    en_b <= 8'h3F;
    oe_b <= 8'h40;
    out_b <= 8'h40;
    wr(gpp_pkg::OFS_B_DIR, 8'hC0);
    idle(8);
    check(o_pin_b, 8'h40);
    check(o_pin_b_oe_n, 8'h3F);
    rd(gpp_pkg::OFS_B_DATA, 1'b0, 8'h55);
    rd(gpp_pkg::OFS_B_DATA, 1'b1, 8'h00);
    check({6'h00, irq6, irq7}, 8'h02);
    i_standby <= 1'b1;
    idle(4);
    check(o_pin_b_oe_n, 8'h3F);
    ext_b <= 8'hFF;
    en_b <= 8'hFF;
    wr(gpp_pkg::OFS_STANDBY, 8'h03);
    idle(8);
    check(o_pin_b_oe_n & o_pin_a_oe_n, 8'hFF);
    check(o_in_a, 8'h00);
    check(o_in_b & 8'hC0, 8'h40);
    check({7'h00, irq7}, 8'h01);
    i_standby <= 1'b0;
    oe_b <= 8'h00;
    wr(gpp_pkg::OFS_B_DATA, 8'h80);
    idle(4);
    check(o_pin_b, 8'h80);
    report_and_stop();
  end
endmodule // tb_gpio_port_pair_ctrl
